// ===== logic/gtc_pkg.sv
/*
 gtc_pkg: register map, field layout, reset values, mode codes and helper
 decoders for the two general-purpose timers.
 Assumes word-indexed APB access: byte address = 4 * register index.
*/
// Contract
// - irq filter: 0x any event, 10 capture only, 11 reload/compare
// - dead delay code 000 none, 001..111 give 2..128 cycles before active
// - capture flag 1 when latest interrupt was a capture, else 0
// - timer stops while second control bit 7 is 0, counts while 1 until a one-shot reaches reload and parks
// - per timer second control: polarity, prescale, mode; reset 0, RW
// - polarity bit meaning depends on the selected operating mode
package gtc_pkg;

    localparam int GTC_NTMR = 2;
    localparam logic [11:0] GTC_IDX_TMR_HI = 12'hF00;
    localparam logic [11:0] GTC_IDX_STAT = 12'hF20;
    localparam logic [11:0] GTC_IDX_MASK = 12'hF21;
    localparam logic [2:0] GTC_OFS_COUNT = 3'h0;
    localparam logic [2:0] GTC_OFS_RELOAD = 3'h2;
    localparam logic [2:0] GTC_OFS_COMPARE = 3'h4;
    localparam logic [2:0] GTC_OFS_CTL0 = 3'h6;
    localparam logic [2:0] GTC_OFS_CTL1 = 3'h7;
    // indices of the two second control registers
    localparam logic [11:0] GTC_IDX_T0_CTL1 = 12'hF07;
    localparam logic [11:0] GTC_IDX_T1_CTL1 = 12'hF0F;

    localparam int GTC_C1_EN = 7;
    localparam int GTC_C1_POL = 6;
    localparam int GTC_C1_CLOCK_DIVIDE_SELECT_HI = 5;
    localparam int GTC_C1_CLOCK_DIVIDE_SELECT_LO = 3;
    localparam int GTC_C1_MODE_HI = 2;
    localparam int GTC_C1_MODE_LO = 0;
    localparam int GTC_C0_FILT_HI = 6;
    localparam int GTC_C0_FILT_LO = 5;
    localparam int GTC_C0_DEAD_HI = 3;
    localparam int GTC_C0_DEAD_LO = 1;
    localparam int GTC_C0_CAP = 0;
    localparam logic [7:0] GTC_C0_WMASK = 8'h6E;
    localparam logic [7:0] GTC_CTL_RST = 8'h00;
    localparam logic [15:0] GTC_CNT_RST = 16'h0000;
    localparam logic [15:0] GTC_CNT_FIRST = 16'h0001;
    localparam logic [15:0] GTC_RLD_RST = 16'hFFFF;
    localparam logic [15:0] GTC_CMP_RST = 16'h0000;

    localparam logic [2:0] GTC_MODE_ONESHOT = 3'h0;
    localparam logic [2:0] GTC_MODE_CONT = 3'h1;
    localparam logic [2:0] GTC_MODE_COUNTER = 3'h2;
    localparam logic [2:0] GTC_MODE_PWM = 3'h3;
    localparam logic [2:0] GTC_MODE_CAPTURE = 3'h4;

    // dead delay in cycles: 0, then 2 ** code
    function automatic logic [7:0] gtc_dead_cycles(input logic [2:0] code);
        gtc_dead_cycles = (code == 3'h0) ? 8'h00 : (8'h01 << code);
    endfunction

    // prescale tick mask: low clock_divide_select bits of the divider all set
    function automatic logic [6:0] gtc_clock_divide_select_mask(input logic [2:0] clock_divide_select);
        gtc_clock_divide_select_mask = 7'((8'h01 << clock_divide_select) - 8'h01);
    endfunction

endpackage

// ===== logic/gtc_dead_time.sv
/*
 gtc_dead_time: holds a timer output and its complement inactive for a
 programmed number of cycles after each change of the raw output level.
 Assumes level and code come from logic on the same clock.
*/
`timescale 1ns/1ps
module gtc_dead_time
    import gtc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic level,
    input wire logic [2:0] code,
    output logic out,
    output logic out_n
);

    logic last_r;
    logic last_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    logic out_n_r;
    logic out_n_nxt;

    always_comb
    begin
        last_nxt = last_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        out_n_nxt = out_n_r;
        if (level != last_r)
        begin
            last_nxt = level;
            if (gtc_dead_cycles(code) == 8'h00)
            begin
                out_nxt = level;
                out_n_nxt = ~level;
                cnt_nxt = 8'h00;
            end
            else
            begin
                // both sides off so they never overlap
                out_nxt = 1'b0;
                out_n_nxt = 1'b0;
                cnt_nxt = gtc_dead_cycles(code);
            end
        end
        else if (cnt_r != 8'h00)
        begin
            cnt_nxt = cnt_r - 8'h01;
            if (cnt_r == 8'h01)
            begin
                out_nxt = last_r;
                out_n_nxt = ~last_r;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_r <= 1'b0;
            cnt_r <= 8'h00;
            out_r <= 1'b0;
            out_n_r <= 1'b1;
        end
        else if (ce)
        begin
            last_r <= last_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
            out_n_r <= out_n_nxt;
        end
    end

    assign out = out_r;
    assign out_n = out_n_r;

endmodule

// ===== logic/gtc_top.sv
/*
 gtc_top: two general-purpose timers with APB register access, interrupt
 filtering, capture-cause flag, prescaler, dead delay and one interrupt.
 Assumes an APB master on clock; timer_in pins are asynchronous.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module gtc_top
    import gtc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [1:0] timer_in,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [1:0] timer_out,
    output logic [1:0] timer_out_n
);

    function automatic logic is_timer_idx(input logic [11:0] idx);
        logic [2:0] o;
        o = idx[2:0];
        is_timer_idx = (idx[11:4] == GTC_IDX_TMR_HI[11:4])
            && (o == GTC_OFS_COUNT || o == GTC_OFS_RELOAD
            || o == GTC_OFS_COMPARE || o == GTC_OFS_CTL0
            || o == GTC_OFS_CTL1);
    endfunction

    // input synchronisers and edge history
    // stage three is history only: nothing reads stage one but stage two
    logic [1:0] in_s1_r;
    logic [1:0] in_s2_r;
    logic [1:0] in_s3_r;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            in_s1_r <= 2'h0;
            in_s2_r <= 2'h0;
            in_s3_r <= 2'h0;
        end
        else if (ce)
        begin
            in_s1_r <= timer_in;
            in_s2_r <= in_s1_r;
            in_s3_r <= in_s2_r;
        end
    end

    // APB slave
    logic [11:0] idx;
    logic acc;
    logic wr_en;
    logic tmr_hit;
    logic mapped;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;

    logic [15:0] cnt_w [GTC_NTMR];
    logic [15:0] rld_w [GTC_NTMR];
    logic [15:0] cmp_w [GTC_NTMR];
    logic [7:0] c0_w [GTC_NTMR];
    logic [7:0] c1_w [GTC_NTMR];
    logic [1:0] tirq;
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic irq_r;
    logic irq_nxt;

    assign idx = paddr[13:2];
    assign tmr_hit = is_timer_idx(idx);
    assign mapped = tmr_hit || idx == GTC_IDX_STAT || idx == GTC_IDX_MASK;
    // one fixed wait state: pready is registered off the first access cycle
    assign acc = psel && penable && !pready_r;
    // writes land only on the edge that completes the access
    assign wr_en = psel && penable && pready_r && pwrite;

    always_comb
    begin
        pready_nxt = acc;
        pslverr_nxt = acc && !mapped;
        prdata_nxt = prdata_r;
        if (acc)
        begin
            prdata_nxt = 32'h0000_0000;
            if (tmr_hit)
            begin
                case (idx[2:0])
                    GTC_OFS_COUNT: prdata_nxt[15:0] = cnt_w[idx[3]];
                    GTC_OFS_RELOAD: prdata_nxt[15:0] = rld_w[idx[3]];
                    GTC_OFS_COMPARE: prdata_nxt[15:0] = cmp_w[idx[3]];
                    GTC_OFS_CTL0: prdata_nxt[7:0] = c0_w[idx[3]];
                    GTC_OFS_CTL1: prdata_nxt[7:0] = c1_w[idx[3]];
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
            else if (idx == GTC_IDX_STAT)
            begin
                prdata_nxt[1:0] = stat_r;
            end
            else if (idx == GTC_IDX_MASK)
            begin
                prdata_nxt[1:0] = mask_r;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    // interrupt status, write one to clear; a new event beats the clear
    always_comb
    begin
        stat_nxt = stat_r;
        mask_nxt = mask_r;
        if (wr_en && idx == GTC_IDX_STAT)
        begin
            stat_nxt = stat_r & ~pwdata[1:0];
        end
        if (wr_en && idx == GTC_IDX_MASK)
        begin
            mask_nxt = pwdata[1:0];
        end
        stat_nxt = stat_nxt | tirq;
        irq_nxt = |(stat_nxt & mask_nxt);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stat_r <= 2'h0;
            mask_r <= 2'h0;
            irq_r <= 1'b0;
        end
        else if (ce)
        begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r <= irq_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < GTC_NTMR; g++)
        begin : tmr
            logic [7:0] c1_r;
            logic [7:0] c1_nxt;
            logic [7:0] c0_r;
            logic [7:0] c0_nxt;
            logic [15:0] cnt_r;
            logic [15:0] cnt_nxt;
            logic [15:0] rld_r;
            logic [15:0] rld_nxt;
            logic [15:0] cmp_r;
            logic [15:0] cmp_nxt;
            logic [6:0] pre_r;
            logic [6:0] pre_nxt;
            logic act_r;
            logic act_nxt;
            logic done_r;
            logic done_nxt;
            logic en;
            logic pol;
            logic [2:0] mode;
            logic [6:0] pmask;
            logic in_edge;
            logic tick;
            logic ev_rld;
            logic ev_cmp;
            logic ev_cap;
            logic ev_irq;
            logic wr_t;

            assign en = c1_r[GTC_C1_EN];
            assign pol = c1_r[GTC_C1_POL];
            assign mode = c1_r[GTC_C1_MODE_HI:GTC_C1_MODE_LO];
            assign pmask = gtc_clock_divide_select_mask(
                c1_r[GTC_C1_CLOCK_DIVIDE_SELECT_HI:GTC_C1_CLOCK_DIVIDE_SELECT_LO]);
            assign wr_t = wr_en && tmr_hit && idx[3] == 1'(g);
            // input modes: polarity picks the edge, 0 rising, 1 falling
            assign in_edge = pol ? (in_s3_r[g] && !in_s2_r[g])
                : (!in_s3_r[g] && in_s2_r[g]);
            assign tick = en && !done_r
                && ((mode == GTC_MODE_COUNTER) ? in_edge
                : ((pre_r & pmask) == pmask));
            assign ev_rld = tick && cnt_r == rld_r;
            assign ev_cmp = tick && mode == GTC_MODE_PWM && cnt_r == cmp_r;
            // capture is gated by enable only, not by the one-shot stop
            assign ev_cap = en && mode == GTC_MODE_CAPTURE && in_edge;

            always_comb
            begin
                case (c0_r[GTC_C0_FILT_HI:GTC_C0_FILT_LO])
                    2'b10: ev_irq = ev_cap;
                    2'b11: ev_irq = ev_rld || ev_cmp;
                    default: ev_irq = ev_rld || ev_cmp || ev_cap;
                endcase
            end

            always_comb
            begin
                c1_nxt = c1_r;
                c0_nxt = c0_r;
                cnt_nxt = cnt_r;
                rld_nxt = rld_r;
                cmp_nxt = cmp_r;
                act_nxt = act_r;
                done_nxt = done_r;
                pre_nxt = en ? pre_r + 7'h01 : 7'h00;
                if (!en)
                begin
                    done_nxt = 1'b0;
                end
                if (tick)
                begin
                    cnt_nxt = ev_rld ? GTC_CNT_FIRST : cnt_r + 16'h0001;
                end
                if (mode == GTC_MODE_PWM)
                begin
                    if (ev_cmp)
                    begin
                        act_nxt = 1'b0;
                    end
                    if (ev_rld)
                    begin
                        act_nxt = 1'b1;
                    end
                end
                else if (ev_rld)
                begin
                    act_nxt = ~act_r;
                end
                // one-shot parks here until software clears the enable
                if (ev_rld && mode == GTC_MODE_ONESHOT)
                begin
                    done_nxt = 1'b1;
                end
                if (ev_irq)
                begin
                    c0_nxt[GTC_C0_CAP] = ev_cap;
                end
                if (wr_t)
                begin
                    case (idx[2:0])
                        GTC_OFS_COUNT: cnt_nxt = pwdata[15:0];
                        GTC_OFS_RELOAD: rld_nxt = pwdata[15:0];
                        GTC_OFS_COMPARE: cmp_nxt = pwdata[15:0];
                        GTC_OFS_CTL0: c0_nxt = (c0_nxt & ~GTC_C0_WMASK)
                            | (pwdata[7:0] & GTC_C0_WMASK);
                        GTC_OFS_CTL1: c1_nxt = pwdata[7:0];
                        default: c1_nxt = c1_r;
                    endcase
                end
                // a capture beats a software write of the same register
                if (ev_cap)
                begin
                    cmp_nxt = cnt_r;
                end
            end

            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    c1_r <= GTC_CTL_RST;
                    c0_r <= GTC_CTL_RST;
                    cnt_r <= GTC_CNT_RST;
                    rld_r <= GTC_RLD_RST;
                    cmp_r <= GTC_CMP_RST;
                    pre_r <= 7'h00;
                    act_r <= 1'b0;
                    done_r <= 1'b0;
                end
                else if (ce)
                begin
                    c1_r <= c1_nxt;
                    c0_r <= c0_nxt;
                    cnt_r <= cnt_nxt;
                    rld_r <= rld_nxt;
                    cmp_r <= cmp_nxt;
                    pre_r <= pre_nxt;
                    act_r <= act_nxt;
                    done_r <= done_nxt;
                end
            end

            assign cnt_w[g] = cnt_r;
            assign rld_w[g] = rld_r;
            assign cmp_w[g] = cmp_r;
            assign c0_w[g] = c0_r;
            assign c1_w[g] = c1_r;
            assign tirq[g] = ev_irq;

            // output modes: polarity inverts the driven level
            gtc_dead_time u_dead (
                .clock(clock),
                .rst_n(rst_n),
                .ce(ce),
                .level(act_r ^ pol),
                .code(c0_r[GTC_C0_DEAD_HI:GTC_C0_DEAD_LO]),
                .out(timer_out[g]),
                .out_n(timer_out_n[g])
            );
        end
    endgenerate

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq = irq_r;

endmodule

// ===== sim/gtc_assertions.sv
/*
 gtc_assertions: port-level checks for gtc_top.
 Assumes one clock domain and a bind by port name.
*/
`timescale 1ns/1ps
module gtc_chk (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [1:0] timer_out,
    input wire logic [1:0] timer_out_n
);
    // run length of both timer 0 outputs held low
    logic [8:0] gap_r;
    logic [8:0] gap_nxt;

    always_comb
    begin
        gap_nxt = 9'h000;
        if (!timer_out[0] && !timer_out_n[0])
            gap_nxt = (gap_r == 9'h1FF) ? gap_r : gap_r + 9'h001;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            gap_r <= 9'h000;
        else
            gap_r <= gap_nxt;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    access_answer_a:
        assert property (psel && penable && !pready && ce |=> pready)
        else $error("access not answered one cycle after enable");
    ready_cause_a:
        assert property (pready |-> $past(psel && penable) && $past(psel, 2))
        else $error("ready without a full access");
    err_ready_a:
        assert property (pslverr |-> pready)
        else $error("error flag outside an answer");
    err_zero_a:
        assert property (pslverr |-> prdata == 32'h0)
        else $error("refused access returned data");
    unmapped_err_a:
        assert property (pready && paddr[13:8] != 6'h3C |-> pslverr)
        else $error("unmapped access not refused");
    out_excl_a:
        assert property ((timer_out & timer_out_n) == 2'b00)
        else $error("output and complement active together");
    dead_bound_a:
        assert property (gap_r <= 9'h080)
        else $error("dead gap longer than the largest code");
    irq_clear_a:
        assert property ($fell(irq) |-> $past(pwrite && pready))
        else $error("interrupt dropped without a write");

    cover property ($rose(irq));
    cover property (pslverr);
    cover property (gap_r == 9'h080);
endmodule

bind gtc_top gtc_chk u_chk (.clock, .rst_n, .ce, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .irq, .timer_out, .timer_out_n);

// ===== sim/gtc_tb.sv
/*
 gtc_tb: self-checking bench for gtc_top driven over APB.
 Assumes gtc_assertions.sv is compiled with it; ce low only in one test.
*/
`timescale 1ns/1ps
module testbench
    import gtc_pkg::*;
;
    logic clock, rst_n, ce, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] timer_in, timer_out, timer_out_n;
    int fail_count, num_checks, cycles;

    gtc_top dut (.clock, .rst_n, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .timer_in, .prdata, .pready, .pslverr, .irq, .timer_out,
        .timer_out_n);

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [11:0] i,
        input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        chk("answer", 32'h1, 32'(n < 16));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string s, input logic [11:0] i,
        input logic [31:0] e);
        apb(1'b0, i, 32'h0);
        chk(s, e, rd);
    endtask

    task automatic irqchk(input logic e);
        @(negedge clock);
        chk("irq", 32'(e), 32'(irq));
    endtask

    task automatic stat(input logic [31:0] s, input logic f);
        rchk("status", 12'hF20, s);
        apb(1'b0, 12'hF0E, 32'h0);
        chk("capture flag", 32'(f), 32'(rd[0]));
        irqchk(s[1]);
    endtask

    // input pin passes a two-stage synchroniser, so allow settle time
    task automatic pin(input logic v);
        @(posedge clock);
        timer_in[1] <= v;
        repeat (8) @(posedge clock);
    endtask

    task automatic t_regs();
        chk("out", 32'h0, 32'(timer_out));
        chk("out_n", 32'h3, 32'(timer_out_n));
        rchk("ctl1 t0", 12'hF07, 32'h0);
        rchk("ctl1 t1", 12'hF0F, 32'h0);
        apb(1'b1, 12'hF07, 32'h7F);
        apb(1'b1, 12'hF0F, 32'h5A);
        rchk("ctl1 t0", 12'hF07, 32'h7F);
        rchk("ctl1 t1", 12'hF0F, 32'h5A);
        apb(1'b1, 12'hF07, 32'h0);
        apb(1'b1, 12'hF0F, 32'h0);
        apb(1'b1, 12'hF06, 32'hFF);
        rchk("ctl0 t0", 12'hF06, 32'h6E);
        apb(1'b1, 12'hF06, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk("slverr", 32'h1, 32'(err));
        chk("unmapped", 32'h0, rd);
    endtask

    // 64-cycle window holds a whole number of ticks for every divider used
    task automatic t_count();
        logic [15:0] c, d;
        for (int p = 0; p < 8; p++)
        begin
            apb(1'b1, 12'hF07, 32'h0);
            apb(1'b1, 12'hF00, 32'h0);
            apb(1'b1, 12'hF07, (p < 7) ? 32'h81 | 32'(p << 3) : 32'h01);
            apb(1'b0, 12'hF00, 32'h0);
            c = rd[15:0];
            repeat (60) @(posedge clock);
            apb(1'b0, 12'hF00, 32'h0);
            d = rd[15:0] - c;
            chk("ticks", (p < 7) ? 32'(64 >> p) : 32'h0, 32'(d));
        end
    endtask

    task automatic t_dead();
        int run, mx, tg;
        logic last;
        apb(1'b1, 12'hF02, 32'h200);
        apb(1'b1, 12'hF04, 32'h100);
        for (int k = 0; k < 8; k++)
        begin
            apb(1'b1, 12'hF07, 32'h0);
            apb(1'b1, 12'hF06, 32'(k << 1));
            apb(1'b1, 12'hF00, 32'h0);
            apb(1'b1, 12'hF07, 32'h83);
            run = 0;
            mx = 0;
            tg = 0;
            last = timer_out[0];
            repeat (1200)
            begin
                @(negedge clock);
                run = (timer_out[0] === 1'b0 && timer_out_n[0] === 1'b0)
                    ? run + 1 : 0;
                if (run > mx)
                    mx = run;
                if (timer_out[0] !== last)
                    tg++;
                last = timer_out[0];
            end
            chk("dead gap", 32'(k == 0 ? 0 : 1 << k), 32'(mx));
            chk("toggles", 32'h1, 32'(tg >= 2));
        end
        apb(1'b1, 12'hF07, 32'h0);
    endtask

    task automatic t_capture();
        apb(1'b1, 12'hF0A, 32'h10);
        apb(1'b1, 12'hF08, 32'h0);
        apb(1'b1, 12'hF0E, 32'h40);
        apb(1'b1, 12'hF21, 32'h2);
        apb(1'b1, 12'hF0F, 32'h84);
        apb(1'b1, 12'hF20, 32'h3);
        repeat (60) @(posedge clock);
        rchk("status", 12'hF20, 32'h0);
        pin(1'b1);
        stat(32'h2, 1'b1);
        apb(1'b1, 12'hF21, 32'h0);
        irqchk(1'b0);
        apb(1'b1, 12'hF21, 32'h2);
        irqchk(1'b1);
        apb(1'b1, 12'hF20, 32'h3);
        irqchk(1'b0);
        apb(1'b1, 12'hF0F, 32'hC4);
        pin(1'b0);
        stat(32'h2, 1'b1);
        apb(1'b1, 12'hF20, 32'h3);
        pin(1'b1);
        stat(32'h0, 1'b1);
        apb(1'b1, 12'hF0E, 32'h60);
        apb(1'b1, 12'hF20, 32'h3);
        repeat (40) @(posedge clock);
        stat(32'h2, 1'b0);
        apb(1'b1, 12'hF0F, 32'h04);
        apb(1'b1, 12'hF0A, 32'hFFFF);
        apb(1'b1, 12'hF08, 32'h0);
        apb(1'b1, 12'hF0E, 32'h0);
        apb(1'b1, 12'hF0F, 32'h84);
        apb(1'b1, 12'hF20, 32'h3);
        pin(1'b0);
        stat(32'h0, 1'b0);
        pin(1'b1);
        stat(32'h2, 1'b1);
        apb(1'b1, 12'hF0A, 32'h8);
        apb(1'b1, 12'hF08, 32'h0);
        apb(1'b1, 12'hF20, 32'h3);
        repeat (40) @(posedge clock);
        stat(32'h2, 1'b0);
    endtask

    // one-shot stop, clock-enable freeze and input-edge counting
    task automatic t_modes();
        logic [15:0] c;
        apb(1'b1, 12'hF07, 32'h0);
        apb(1'b1, 12'hF06, 32'h0);
        apb(1'b1, 12'hF02, 32'h4);
        apb(1'b1, 12'hF00, 32'h0);
        apb(1'b1, 12'hF07, 32'h80);
        repeat (20) @(posedge clock);
        rchk("one-shot", 12'hF00, 32'h1);
        apb(1'b1, 12'hF07, 32'h0);
        apb(1'b1, 12'hF02, 32'hFFFF);
        apb(1'b1, 12'hF00, 32'h0);
        apb(1'b1, 12'hF07, 32'h81);
        apb(1'b0, 12'hF00, 32'h0);
        c = rd[15:0];
        repeat (20) @(posedge clock);
        ce <= 1'b0;
        repeat (20) @(posedge clock);
        ce <= 1'b1;
        repeat (20) @(posedge clock);
        apb(1'b0, 12'hF00, 32'h0);
        chk("frozen", 32'd44, 32'(rd[15:0] - c));
        apb(1'b1, 12'hF0F, 32'h0);
        apb(1'b1, 12'hF08, 32'h0);
        apb(1'b1, 12'hF0F, 32'h82);
        pin(1'b0);
        pin(1'b1);
        pin(1'b0);
        pin(1'b1);
        rchk("edges", 12'hF08, 32'h2);
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        timer_in = 2'b00;
        rst_n = 1'b0;
        fail_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_count();
        t_dead();
        t_capture();
        t_modes();
        tally_and_finish();
    end
endmodule
